// >>> tlb_buf2.sv
// two-entry skid buffer, a receiver stall loses no word
// assumes synchronous active-high reset
`include "tlb_map.svh"
module tlb_buf2
  import tlb_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  tlb_buf_if.snk    in_if,
  output      logic out_valid_o,
  output tlb_word_t out_data_o,
  input  wire logic out_ready_i
);
  typedef struct packed {
    tlb_word_t  d0;
    tlb_word_t  d1;
    logic [1:0] cnt;
  } tlb_buf_st_t;
  tlb_buf_st_t st_r;
  tlb_buf_st_t st_nxt;
  logic        push;
  logic        pop;
  assign in_if.ready = (st_r.cnt != `TLB_BUF_FULL);
  assign out_valid_o = (st_r.cnt != `TLB_BUF_EMPTY);
  assign out_data_o  = st_r.d0;
  assign push        = in_if.valid && in_if.ready;
  assign pop         = out_valid_o && out_ready_i;
  always_comb begin
    st_nxt = st_r;
    if (pop) begin
      st_nxt.d0 = st_r.d1;
    end
    if (push) begin
      if (st_r.cnt == `TLB_BUF_EMPTY ||
          (st_r.cnt == `TLB_BUF_ONE && pop)) begin
        st_nxt.d0 = in_if.data;
      end else begin
        st_nxt.d1 = in_if.data;
      end
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // tlb_buf2

// >>> tlb_buf_if.sv
// word stream carrier between generator and the two-entry buffer
// assumes both ends on SYS_CLK_I
interface tlb_buf_if;
  import tlb_pkg::*;
  logic      valid;
  logic      ready;
  tlb_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> tlb_checker.sv
// assertions on the loopback block ports in parallel self-test mode
// assumes the one tlb_loopback instance is built with MODE=TLB_PAR_BIST
module tlb_checker
  import tlb_pkg::*;
(
  input wire logic        SYS_CLK_I,
  input wire logic        SRST_I,
  input wire logic        TX_DIG_RST_I,
  input wire logic        RX_DIG_RST_I,
  input wire logic [15:0] TX_PCS_DATA_O,
  input wire logic        TX_PCS_VALID_O,
  input wire logic        TX_PCS_READY_I,
  input wire logic        TX_SER_BIT_I,
  input wire logic        TX_LINE_BIT_O,
  input wire logic        RX_FAB_VALID_O,
  input wire logic        BIST_DONE_O,
  input wire logic        BIST_ERR_O,
  input wire logic        REV_PAR_ACTIVE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  AST_NO_RX_FAB: assert property (!RX_FAB_VALID_O)
    else $error("fabric rx valid during self-test");
  AST_NO_REV_PAR: assert property (!REV_PAR_ACTIVE_O)
    else $error("reverse parallel active outside pcie");
  AST_ERR_HOLD: assert property (BIST_ERR_O && !RX_DIG_RST_I |=> BIST_ERR_O)
    else $error("error flag dropped");
  AST_DONE_HOLD: assert property (BIST_DONE_O && !RX_DIG_RST_I |=> $stable(BIST_DONE_O))
    else $error("done flag dropped");
  AST_ERR_DONE: assert property (BIST_ERR_O |-> BIST_DONE_O)
    else $error("error without done");
  AST_RX_CLR: assert property (RX_DIG_RST_I |=> !BIST_DONE_O && !BIST_ERR_O)
    else $error("rx reset left a flag set");
  // buffer is emptied too, so the first word out must be the restart value
  AST_TX_CLR: assert property ($fell(TX_DIG_RST_I) |-> ##[0:3]
    (TX_PCS_VALID_O && TX_PCS_DATA_O == 16'h0000))
    else $error("generator did not restart at zero");
  AST_INCR: assert property (disable iff (SRST_I || TX_DIG_RST_I)
    TX_PCS_VALID_O && TX_PCS_READY_I ##1 TX_PCS_VALID_O |->
    TX_PCS_DATA_O == $past(TX_PCS_DATA_O) + 16'h0001)
    else $error("pattern not incrementing");
  AST_LINE: assert property (!$past(SRST_I) |->
    TX_LINE_BIT_O == $past(TX_SER_BIT_I))
    else $error("line bit not serializer bit");
  cover property (BIST_DONE_O && !BIST_ERR_O);
  cover property (BIST_ERR_O);
  cover property ($fell(TX_DIG_RST_I));
endmodule // tlb_checker

bind tlb_loopback tlb_checker tlb_checker_inst (.SYS_CLK_I(SYS_CLK_I),
  .SRST_I(SRST_I), .TX_DIG_RST_I(TX_DIG_RST_I), .RX_DIG_RST_I(RX_DIG_RST_I),
  .TX_PCS_DATA_O(TX_PCS_DATA_O), .TX_PCS_VALID_O(TX_PCS_VALID_O),
  .TX_PCS_READY_I(TX_PCS_READY_I), .TX_SER_BIT_I(TX_SER_BIT_I),
  .TX_LINE_BIT_O(TX_LINE_BIT_O), .RX_FAB_VALID_O(RX_FAB_VALID_O),
  .BIST_DONE_O(BIST_DONE_O), .BIST_ERR_O(BIST_ERR_O),
  .REV_PAR_ACTIVE_O(REV_PAR_ACTIVE_O));

// >>> tlb_loopback.sv
// channel loopback and self-test logic between fabric and line datapath
// assumes all ports synchronous to SYS_CLK_I; mode is static configuration
`include "tlb_map.svh"
module tlb_loopback
  import tlb_pkg::*;
#(
  parameter tlb_mode_t MODE         = TLB_NORMAL,
  parameter logic      DOUBLE_WIDTH = 1'b0,
  parameter logic      PCIE_MODE    = 1'b0,
  parameter logic      PCIE_GEN3    = 1'b0
)
(
  input  wire logic                    SYS_CLK_I,
  input  wire logic                    SRST_I,
  input  wire logic                    TX_DIG_RST_I,
  input  wire logic                    RX_DIG_RST_I,
  input  wire logic [`TLB_W-1:0]       TX_FAB_DATA_I,
  input  wire logic                    TX_FAB_VALID_I,
  output      logic                    TX_FAB_READY_O,
  output      logic [`TLB_W-1:0]       TX_PCS_DATA_O,
  output      logic                    TX_PCS_VALID_O,
  input  wire logic                    TX_PCS_READY_I,
  input  wire logic [`TLB_W-1:0]       RX_PCS_DATA_I,
  input  wire logic                    RX_PCS_VALID_I,
  input  wire logic [`TLB_W-1:0]       RX_ALIGNED_DATA_I,
  input  wire logic                    RX_ALIGNED_VALID_I,
  input  wire logic                    RX_CDR_BIT_I,
  input  wire logic                    RX_RAW_BIT_I,
  input  wire logic                    TX_SER_BIT_I,
  output      logic                    TX_LINE_BIT_O,
  output      logic [`TLB_W-1:0]       RX_FAB_DATA_O,
  output      logic                    RX_FAB_VALID_O,
  input  wire logic                    DETECT_RX_LPBK_I,
  input  wire logic [`TLB_SWING_W-1:0] OUTPUT_SWING_SETTING_I,
  input  wire logic [`TLB_TAP_W-1:0]   POST_TAP1_I,
  output      logic [`TLB_SWING_W-1:0] OUTPUT_SWING_SETTING_O,
  output      logic [`TLB_TAP_W-1:0]   POST_TAP1_O,
  output      logic                    ENC_8B10B_EN_O,
  output      logic                    BYTE_SER_EN_O,
  output      logic                    WIDTH16_O,
  output      logic                    BIST_DONE_O,
  output      logic                    BIST_ERR_O,
  output      logic                    REV_PAR_ACTIVE_O
);
  typedef struct packed {
    tlb_word_t                gen_word;
    tlb_word_t                exp_word;
    tlb_chk_st_t              chk_st;
    logic                     done;
    logic                     err;
    tlb_word_t                rx_data;
    logic                     rx_valid;
    logic                     line_bit;
    logic [`TLB_SWING_W-1:0]  swing;
    logic [`TLB_TAP_W-1:0]    tap;
    logic                     rev_par;
  } tlb_st_t;
  tlb_st_t st_r;
  tlb_st_t st_nxt;
  localparam logic BIST_ON = (MODE == TLB_PAR_BIST);
  // reverse parallel is only legal in pcie mode at first or second rate
  localparam logic REV_PAR_OK = (MODE == TLB_REV_PAR_PCIE) && PCIE_MODE
                                && !PCIE_GEN3;
  function automatic tlb_word_t tlb_incr(input tlb_word_t w);
    tlb_incr = w + `TLB_ONE;
  endfunction
  tlb_buf_if gen_if ();
  logic      buf_valid;
  tlb_word_t buf_data;
  logic      gen_push;
  // generator word sits at fabric edge so full pcs path is exercised
  assign gen_if.valid = BIST_ON ? 1'b1 : TX_FAB_VALID_I;
  assign gen_if.data  = BIST_ON ? st_r.gen_word : TX_FAB_DATA_I;
  assign gen_push     = BIST_ON && gen_if.ready;
  assign TX_FAB_READY_O = BIST_ON ? 1'b0 : gen_if.ready;
  tlb_buf2 tlb_buf2_inst (
    .clk_i       (SYS_CLK_I),
    .rst_i       (SRST_I || TX_DIG_RST_I),
    .in_if       (gen_if),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (TX_PCS_READY_I)
  );
  assign TX_PCS_VALID_O = buf_valid;
  assign TX_PCS_DATA_O  = buf_data;
  assign ENC_8B10B_EN_O = BIST_ON ? 1'b1 : 1'b1;
  assign BYTE_SER_EN_O  = BIST_ON ? !DOUBLE_WIDTH : !DOUBLE_WIDTH;
  assign WIDTH16_O      = BIST_ON ? 1'b1 : DOUBLE_WIDTH;
  assign OUTPUT_SWING_SETTING_O = st_r.swing;
  assign POST_TAP1_O    = st_r.tap;
  assign TX_LINE_BIT_O  = st_r.line_bit;
  assign RX_FAB_DATA_O  = st_r.rx_data;
  assign RX_FAB_VALID_O = st_r.rx_valid;
  assign BIST_DONE_O    = st_r.done;
  assign BIST_ERR_O     = st_r.err;
  assign REV_PAR_ACTIVE_O = st_r.rev_par;
  always_comb begin
    st_nxt = st_r;
    // generator advances on each accepted word, wraps at ffff
    if (TX_DIG_RST_I) begin
      st_nxt.gen_word = `TLB_ZERO;
    end else if (gen_push) begin
      st_nxt.gen_word = tlb_incr(st_r.gen_word);
    end
    // checker, low byte runs 00 through ff repeatedly
    if (RX_DIG_RST_I) begin
      st_nxt.chk_st   = TLB_CHK_WAIT;
      st_nxt.exp_word = `TLB_ZERO;
      st_nxt.done     = 1'b0;
      st_nxt.err      = 1'b0;
    end else if (BIST_ON && RX_PCS_VALID_I) begin
      case (st_r.chk_st)
        TLB_CHK_WAIT: begin
          // first word seeds the expectation; link latency is unknown
          st_nxt.exp_word = tlb_incr(RX_PCS_DATA_I);
          st_nxt.chk_st   = TLB_CHK_RUN;
        end
        TLB_CHK_RUN: begin
          if (RX_PCS_DATA_I != st_r.exp_word) begin
            st_nxt.err    = 1'b1;
            st_nxt.done   = 1'b1;
            st_nxt.chk_st = TLB_CHK_END;
          end else begin
            st_nxt.exp_word = tlb_incr(st_r.exp_word);
            if (RX_PCS_DATA_I[`TLB_LO_BYTE] == `TLB_BYTE_LAST) begin
              st_nxt.done   = 1'b1;
              st_nxt.chk_st = TLB_CHK_END;
            end
          end
        end
        TLB_CHK_END: begin
          // flags sticky until receive reset; later errors still latch
          if (RX_PCS_DATA_I != st_r.exp_word) begin
            st_nxt.err = 1'b1;
          end
          st_nxt.exp_word = tlb_incr(RX_PCS_DATA_I);
        end
        default: begin
          st_nxt.chk_st = TLB_CHK_WAIT;
        end
      endcase
    end
    // receive data to fabric, pattern held back in self-test
    if (BIST_ON) begin
      st_nxt.rx_data  = `TLB_ZERO;
      st_nxt.rx_valid = 1'b0;
    end else if (MODE == TLB_REV_PAR_PCIE) begin
      st_nxt.rx_data  = RX_ALIGNED_DATA_I;
      st_nxt.rx_valid = RX_ALIGNED_VALID_I;
    end else begin
      st_nxt.rx_data  = RX_PCS_DATA_I;
      st_nxt.rx_valid = RX_PCS_VALID_I;
    end
    // reverse parallel follows the fabric request level
    st_nxt.rev_par = REV_PAR_OK && DETECT_RX_LPBK_I;
    // serial output source; modes are static, no runtime select
    case (MODE)
      TLB_REV_SERIAL:   st_nxt.line_bit = RX_CDR_BIT_I;
      TLB_REV_PRECDR:   st_nxt.line_bit = RX_RAW_BIT_I;
      default:          st_nxt.line_bit = TX_SER_BIT_I;
    endcase
    // driver settings
    st_nxt.swing = OUTPUT_SWING_SETTING_I;
    if (MODE == TLB_REV_PRECDR) begin
      st_nxt.tap = `TLB_TAP_RST;
    end else begin
      st_nxt.tap = POST_TAP1_I;
    end
  end
  // when rev_par is high the pcs sends aligned rate-matched words
  // to the serializer; this block only reports that selection
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      st_r          <= '0;
      st_r.chk_st   <= TLB_CHK_WAIT;
      st_r.swing    <= `TLB_SWING_RST;
      st_r.tap      <= `TLB_TAP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // tlb_loopback

// >>> tlb_map.svh
// constants for the transceiver loopback and self-test block
// assumes one 200 MHz clock and a synchronous active-high reset
// Overview of operation
// - generator and checker sit at the fabric edge of the parallel path
// - parallel loopback works only with the 16-bit incrementing generator
// - parallel width is forced to sixteen bits during parallel loopback
// - incrementing 00 to ff pattern loops back into receive path before line
// - generated pattern also goes out on the serial transmit output
// - test pattern never reaches the fabric receive data bus
// - encoder on in both widths; byte serializer only in single width
// - done flag set and held after one full pass or a mismatch
// - error flag set and held on the first mismatch
// - transmit reset clears generator, receive reset clears checker and flags
// - reverse serial loopback sends retimed received data out, fabric too
// - reverse serial loopback is a static configuration, no runtime pin
// - reverse serial loopback keeps swing and first post tap adjustable
// - pre-recovery loopback sends raw input out, fabric still receives
// - pre-recovery loopback fixes pre-emphasis; only swing may be set
// - reverse parallel loopback exists only in PCIe mode, gen1 and gen2
// - reverse parallel loopback sends recovered aligned words to serializer
// - reverse parallel loopback keeps delivering receive data to fabric
// - self-test loopback is available in single and double width
`ifndef TLB_MAP_SVH
`define TLB_MAP_SVH
`define TLB_W         16
`define TLB_ZERO      16'h0000
`define TLB_ONE       16'h0001
`define TLB_LAST      16'hffff
`define TLB_BYTE_LAST 8'hff
`define TLB_SWING_W   3
`define TLB_TAP_W     5
`define TLB_SWING_RST 3'h0
`define TLB_TAP_RST   5'h00
`define TLB_BUF_EMPTY 2'h0
`define TLB_BUF_ONE   2'h1
`define TLB_BUF_FULL  2'h2
`define TLB_LO_BYTE   7:0
`endif

// >>> tlb_pcs_model.sv
// line-side pcs model: takes tx words, stalls, hands them back as rx words
// assumes one clock; corrupt_i flips bit 0 of words taken while it is high
module tlb_pcs_model
  import tlb_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire tlb_word_t data_i,
  input  wire logic      valid_i,
  input  wire logic      corrupt_i,
  output      logic      ready_o,
  output      tlb_word_t rx_data_o,
  output      logic      rx_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_r;
  // stall one cycle in four so the buffer fills
  assign ready_o = cnt_r != 2'h3;
  always_ff @(posedge clk_i) begin
    cnt_r <= rst_i ? 2'h0 : cnt_r + 2'h1;
    rx_valid_o <= !rst_i && valid_i && ready_o;
    // idle bus inverts its last value each cycle, so a second idle cycle in a row shows the stale word
    rx_data_o <= (valid_i && ready_o) ? data_i ^ {15'h0000, corrupt_i}
                                      : ~rx_data_o;
  end
endmodule // tlb_pcs_model

// >>> tlb_pkg.sv
// types for the transceiver loopback and self-test block
// assumes tlb_map.svh is on the include path
`include "tlb_map.svh"
package tlb_pkg;
  typedef logic [`TLB_W-1:0] tlb_word_t;
  typedef enum logic [2:0] {
    TLB_NORMAL,
    TLB_PAR_BIST,
    TLB_REV_SERIAL,
    TLB_REV_PRECDR,
    TLB_REV_PAR_PCIE
  } tlb_mode_t;
  typedef enum logic [1:0] {
    TLB_CHK_WAIT,
    TLB_CHK_RUN,
    TLB_CHK_END
  } tlb_chk_st_t;
endpackage

// >>> transceiver_loopback_bist_bench.sv
// bench for the loopback block in parallel self-test mode
// assumes tlb_map.svh on the include path and the pcs model alongside
`include "tlb_map.svh"
module transceiver_loopback_bist_bench
  import tlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] sw;
    logic [4:0] tp;
    logic [2:0] esw;
    logic [4:0] etp;
  } tlb_row_t;
  tlb_row_t   rows [4] = '{'{3'h7, 5'h1f, 3'h7, 5'h1f},
                           '{3'h0, 5'h00, 3'h0, 5'h00},
                           '{3'h5, 5'h0a, 3'h5, 5'h0a},
                           '{3'h2, 5'h15, 3'h2, 5'h15}};
  logic       clk, srst, txr, rxr, bad, frdy, pv, prdy, rv, line, fv;
  logic       enc, bser, w16, done, err, rpa;
  logic [15:0] cnt = 16'h0000;
  tlb_word_t  pd, rd, fd;
  logic [2:0] sw, swo;
  logic [4:0] tp, tpo;
  int         num_errors = 0;
  int         n_tests = 0;
  tlb_loopback #(.MODE(TLB_PAR_BIST)) tlb_loopback_inst (
    .SYS_CLK_I(clk), .SRST_I(srst), .TX_DIG_RST_I(txr), .RX_DIG_RST_I(rxr),
    .TX_FAB_DATA_I(cnt), .TX_FAB_VALID_I(cnt[0]), .TX_FAB_READY_O(frdy),
    .TX_PCS_DATA_O(pd), .TX_PCS_VALID_O(pv), .TX_PCS_READY_I(prdy),
    .RX_PCS_DATA_I(rd), .RX_PCS_VALID_I(rv), .RX_ALIGNED_DATA_I(~cnt),
    .RX_ALIGNED_VALID_I(cnt[1]), .RX_CDR_BIT_I(cnt[2]), .RX_RAW_BIT_I(cnt[3]),
    .TX_SER_BIT_I(cnt[4]), .TX_LINE_BIT_O(line), .RX_FAB_DATA_O(fd),
    .RX_FAB_VALID_O(fv), .DETECT_RX_LPBK_I(cnt[5]),
    .OUTPUT_SWING_SETTING_I(sw), .POST_TAP1_I(tp),
    .OUTPUT_SWING_SETTING_O(swo), .POST_TAP1_O(tpo), .ENC_8B10B_EN_O(enc),
    .BYTE_SER_EN_O(bser), .WIDTH16_O(w16), .BIST_DONE_O(done),
    .BIST_ERR_O(err), .REV_PAR_ACTIVE_O(rpa));
  tlb_pcs_model tlb_pcs_model_inst (.clk_i(clk), .rst_i(srst), .data_i(pd),
    .valid_i(pv), .corrupt_i(bad), .ready_o(prdy), .rx_data_o(rd),
    .rx_valid_o(rv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // free counter keeps every side input but swing and tap moving
  always @(posedge clk) cnt <= #1 cnt + 16'h0001;
  task test_done;
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  function logic pick(input int s);
    case (s)
      0: return done;
      1: return err;
      default: return pv;
    endcase
  endfunction
  task wait_on(input int s);
    for (int i = 0; i < 4000; i++) begin
      if (pick(s) === 1'b1) return;
      @(posedge clk);
      #1;
    end
    chk("wait", 16'h0001, 16'h0000);
    test_done();
  endtask
  task pulse(input int s);
    if (s == 0) txr = 1'b1;
    else rxr = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    txr = 1'b0;
    rxr = 1'b0;
  endtask
  initial begin
    {srst, txr, rxr, bad, sw, tp} = {4'h8, 8'h00};
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    chk("done", 16'h0000, 16'(done));
    chk("err", 16'h0000, 16'(err));
    chk("enc", 16'h0001, 16'(enc));
    chk("bser", 16'h0001, 16'(bser));
    chk("w16", 16'h0001, 16'(w16));
    chk("frdy", 16'h0000, 16'(frdy));
    chk("fv", 16'h0000, 16'(fv));
    foreach (rows[r]) begin
      {sw, tp} = {rows[r].sw, rows[r].tp};
      @(posedge clk);
      #1;
      chk("swing", 16'(rows[r].esw), 16'(swo));
      chk("tap", 16'(rows[r].etp), 16'(tpo));
      chk("fd", 16'h0000, fd);
      chk("rpa", 16'h0000, 16'(rpa));
    end
    wait_on(0);
    chk("err", 16'h0000, 16'(err));
    repeat (300) @(posedge clk);
    #1;
    chk("done", 16'h0001, 16'(done));
    pulse(1);
    chk("done", 16'h0000, 16'(done));
    chk("err", 16'h0000, 16'(err));
    repeat (4) @(posedge clk);
    #1;
    bad = 1'b1;
    wait_on(1);
    bad = 1'b0;
    chk("done", 16'h0001, 16'(done));
    repeat (100) @(posedge clk);
    #1;
    chk("err", 16'h0001, 16'(err));
    pulse(0);
    wait_on(2);
    chk("restart", 16'h0000, pd);
    chk("err", 16'h0001, 16'(err));
    pulse(1);
    wait_on(0);
    chk("err", 16'h0000, 16'(err));
    test_done();
  end
endmodule // transceiver_loopback_bist_bench
